// >>> hw/dlmc_pkg.sv
// Purpose: Shared constants and types for the level, mute and control block
// Assumes: One 125 MHz clock, registers reached on an 8-bit control port
// Notes: Levels are attenuation in 1/8 dB units, LVL_MUTE is quiescent
package dlmc_pkg;
  localparam logic [7:0] ADDR_SILENCE = 8'h04;
  localparam logic [7:0] ADDR_ATT_A = 8'h05;
  localparam logic [7:0] ADDR_ATT_B = 8'h06;
  localparam logic [7:0] ADDR_RAMP = 8'h07;
  localparam logic [7:0] ADDR_MISC = 8'h08;
  localparam logic [7:0] RST_SILENCE = 8'h80;
  localparam logic [7:0] RST_ATT = 8'h00;
  localparam logic [7:0] RST_RAMP = 8'hb1;
  localparam logic [7:0] RST_MISC = 8'h10;
  localparam int SIL_AUTO = 7;
  localparam int SIL_COMBINE = 5;
  localparam int SIL_MUTE_A = 4;
  localparam int SIL_MUTE_B = 3;
  localparam int RF_POL_LO = 6;
  localparam int RF_RAMP_UP = 5;
  localparam int RF_RAMP_DN = 4;
  localparam int RF_ROLLOFF = 2;
  localparam int MISC_PDN = 7;
  localparam int MISC_FREEZE = 5;
  localparam int MISC_STARTUP = 4;
  localparam int MISC_CLK_LO = 2;
  localparam int MISC_RATIO_LO = 0;
  localparam int AUTO_SILENCE_ENABLE_SAMPLES = 8192;
  localparam logic [9:0] ZC_TIMEOUT_SAMPLES = 10'h200;
  localparam int LVL_W = 11;
  localparam logic [10:0] LVL_MUTE = 11'h400;
  localparam logic [1:0] CLK_STD = 2'h0;
  localparam logic [1:0] CLK_WIDE = 2'h1;
  localparam logic [1:0] CLK_MANUAL = 2'h2;
  localparam logic [1:0] SPD_AUTO = 2'h0;
  localparam logic [1:0] SPD_SINGLE = 2'h1;
  localparam logic [1:0] SPD_QUAD = 2'h3;
  localparam logic [9:0] RATIO_512 = 10'h200;
  localparam logic [9:0] RATIO_256 = 10'h100;
  localparam logic [9:0] RATIO_128 = 10'h080;
  localparam logic [9:0] RATIO_64 = 10'h040;
  typedef enum logic [1:0] {
    POL_IMMED = 2'b00,
    POL_ZC = 2'b01,
    POL_SOFT = 2'b10,
    POL_SOFTZC = 2'b11
  } dlmc_policy_e;
  typedef enum logic [1:0] {
    FLT_RUN = 2'b00,
    FLT_DOWN = 2'b01,
    FLT_UP = 2'b10
  } dlmc_flt_e;
endpackage

// >>> hw/dlmc_chan.sv
// Purpose: One channel: auto-silence detect and level-change engine
// Assumes: sample_stb marks one sample, frame_tick one frame period
// Notes: Auto-silence overrides level at the top, so it is instant
`timescale 1ns/1ps
module dlmc_chan #(
  parameter int SILENCE_SAMPLES = dlmc_pkg::AUTO_SILENCE_ENABLE_SAMPLES,
  parameter int SAMPLE_W = 24
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sample_stb,
  input wire logic [SAMPLE_W-1:0] sample_data,
  input wire logic frame_tick,
  input wire logic [7:0] attenuation_code,
  input wire logic mute_req,
  input wire logic auto_en,
  input wire dlmc_pkg::dlmc_policy_e policy,
  input wire logic instant,
  output logic [dlmc_pkg::LVL_W-1:0] level_q,
  output logic auto_muted_q,
  output logic at_target
);
  import dlmc_pkg::*;
  localparam int CW = $clog2(SILENCE_SAMPLES + 1);
  if (SILENCE_SAMPLES < 2 || SAMPLE_W < 2) begin : g_chk
    $error("dlmc_chan: unsupported parameters");
  end
  logic [CW-1:0] run_q;
  logic [9:0] tmo_q;
  logic sign_q;
  logic is_static;
  logic zc;
  logic tmo_hit;
  logic [LVL_W-1:0] target;
  dlmc_policy_e pol;

  function automatic logic [LVL_W-1:0] step_toward(input logic [LVL_W-1:0] cur,
                                                   input logic [LVL_W-1:0] tgt);
    if (cur < tgt) return LVL_W'(cur + 1'b1);
    if (cur > tgt) return LVL_W'(cur - 1'b1);
    return cur;
  endfunction

  assign is_static = (sample_data == '0) || (sample_data == '1);
  assign zc = sample_stb && (sample_data[SAMPLE_W-1] != sign_q);
  assign tmo_hit = sample_stb && (tmo_q == ZC_TIMEOUT_SAMPLES - 10'h1);
  assign target = mute_req ? LVL_MUTE : {1'b0, attenuation_code, 2'b00};
  assign pol = instant ? POL_IMMED : policy;
  assign at_target = (level_q == target);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_q <= '0;
      auto_muted_q <= 1'b0;
    end else if (!auto_en) begin
      run_q <= '0;
      auto_muted_q <= 1'b0;
    end else if (sample_stb) begin
      if (is_static) begin
        if (run_q != CW'(SILENCE_SAMPLES)) run_q <= CW'(run_q + 1'b1);
        if (run_q == CW'(SILENCE_SAMPLES - 1)) auto_muted_q <= 1'b1;
      end else begin
        run_q <= '0;
        auto_muted_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sign_q <= 1'b0;
    end else if (sample_stb) begin
      sign_q <= sample_data[SAMPLE_W-1];
    end
  end

  // Timeout restarts whenever the level is settled
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmo_q <= '0;
    end else if (at_target || tmo_hit) begin
      tmo_q <= '0;
    end else if (sample_stb) begin
      tmo_q <= tmo_q + 10'h1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_q <= '0;
    end else begin
      unique case (pol)
        POL_IMMED: level_q <= target;
        POL_ZC: if (zc || tmo_hit) level_q <= target;
        POL_SOFT: if (frame_tick) level_q <= step_toward(level_q, target);
        POL_SOFTZC: if (zc || tmo_hit) level_q <= step_toward(level_q, target);
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  auto_silence_set_a: assert property (
    auto_en && sample_stb && is_static && run_q == CW'(SILENCE_SAMPLES - 1)
    |=> auto_muted_q)
    else $error("auto silence not set after last static sample");
  auto_silence_rel_a: assert property (
    sample_stb && !is_static |=> !auto_muted_q)
    else $error("auto silence not released by live sample");
  immed_step_a: assert property (
    pol == POL_IMMED |=> level_q == $past(target))
    else $error("immediate change not applied in one step");
  zc_wait_a: assert property (
    pol == POL_ZC && !zc && !tmo_hit |=> $stable(level_q))
    else $error("zero cross change applied without crossing");
  soft_rate_a: assert property (
    pol == POL_SOFT && !frame_tick |=> $stable(level_q))
    else $error("soft ramp stepped off the frame tick");
  softzc_step_a: assert property (
    pol == POL_SOFTZC && (zc || tmo_hit) && !at_target
    |=> level_q == $past(level_q) + 11'h1 || level_q == $past(level_q) - 11'h1)
    else $error("combined policy step not one eighth dB");
endmodule

// >>> hw/dlmc_top.sv
// Purpose: Control registers, silence indicators, fault ramps and clock ratio
// Assumes: Control port decoded upstream into byte writes and reads
// Notes: Reads return the stored byte, including frozen pending values
`timescale 1ns/1ps
module dlmc_top #(
  parameter int SILENCE_SAMPLES = dlmc_pkg::AUTO_SILENCE_ENABLE_SAMPLES,
  parameter int SAMPLE_W = 24
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata_q,
  input wire logic frame_clock,
  input wire logic sample_valid,
  input wire logic [SAMPLE_W-1:0] sample_a,
  input wire logic [SAMPLE_W-1:0] sample_b,
  input wire logic frame_clock_lost,
  input wire logic [1:0] detected_speed,
  input wire logic [1:0] speed_range_select,
  output logic [dlmc_pkg::LVL_W-1:0] chan_a_level_q,
  output logic [dlmc_pkg::LVL_W-1:0] chan_b_level_q,
  output logic chan_a_silence_indicator_pin,
  output logic chan_b_silence_indicator_pin,
  output logic rolloff_select,
  output logic power_down,
  output logic [9:0] recovered_clock_ratio_q,
  output logic recovered_clock_enable_q
);
  import dlmc_pkg::*;
  if (SILENCE_SAMPLES < 2 || SAMPLE_W < 2) begin : g_chk
    $error("dlmc_top: unsupported parameters");
  end

  // Stored bytes as written
  logic [7:0] sil_q;
  logic [7:0] att_a_q;
  logic [7:0] att_b_q;
  logic [7:0] ramp_q;
  logic [7:0] misc_q;
  // Applied copies that steer the logic
  logic [7:0] ap_sil_q;
  logic [7:0] ap_att_a_q;
  logic [7:0] ap_att_b_q;
  logic [7:0] ap_ramp_q;
  logic [7:0] ap_misc_q;

  logic frame_q;
  logic frame_tick;
  dlmc_flt_e flt_q;
  logic roll_act_q;
  logic [1:0] speed_act_q;
  logic [1:0] speed_eff;
  logic mode_change;
  logic sys_mute;
  logic sys_instant;
  logic power_down_request;
  logic pdn_q;
  logic pup_q;
  logic instant;
  logic mute_a;
  logic mute_b;
  logic [LVL_W-1:0] lvl_a;
  logic [LVL_W-1:0] lvl_b;
  logic auto_a;
  logic auto_b;
  logic tgt_a;
  logic tgt_b;
  logic cond_a;
  logic cond_b;

  // Register writes; every bit is stored so reserved bits read back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sil_q <= RST_SILENCE;
      att_a_q <= RST_ATT;
      att_b_q <= RST_ATT;
      ramp_q <= RST_RAMP;
      misc_q <= RST_MISC;
    end else if (reg_we) begin
      unique case (reg_addr)
        ADDR_SILENCE: sil_q <= reg_wdata;
        ADDR_ATT_A: att_a_q <= reg_wdata;
        ADDR_ATT_B: att_b_q <= reg_wdata;
        ADDR_RAMP: ramp_q <= reg_wdata;
        ADDR_MISC: misc_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_re) begin
      unique case (reg_addr)
        ADDR_SILENCE: reg_rdata_q <= sil_q;
        ADDR_ATT_A: reg_rdata_q <= att_a_q;
        ADDR_ATT_B: reg_rdata_q <= att_b_q;
        ADDR_RAMP: reg_rdata_q <= ramp_q;
        ADDR_MISC: reg_rdata_q <= misc_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Hold-updates gates every applied copy, the bit itself acts at once
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ap_sil_q <= RST_SILENCE;
      ap_att_a_q <= RST_ATT;
      ap_att_b_q <= RST_ATT;
      ap_ramp_q <= RST_RAMP;
      ap_misc_q <= RST_MISC;
    end else if (!misc_q[MISC_FREEZE]) begin
      ap_sil_q <= sil_q;
      ap_att_a_q <= att_a_q;
      ap_att_b_q <= att_b_q;
      ap_ramp_q <= ramp_q;
      ap_misc_q <= misc_q;
    end
  end

  // Frame clock is sampled as a plain input; rising edge is one period
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= frame_clock;
    end
  end
  assign frame_tick = frame_clock && !frame_q;

  assign speed_eff = (speed_range_select == SPD_AUTO) ? detected_speed
                                                      : speed_range_select;
  assign mode_change = (ap_ramp_q[RF_ROLLOFF] != roll_act_q) || (speed_eff != speed_act_q);

  // Filter or speed change: mute, switch while silent, then unmute
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      flt_q <= FLT_RUN;
      roll_act_q <= 1'b0;
      speed_act_q <= SPD_AUTO;
    end else begin
      unique case (flt_q)
        FLT_RUN: begin
          if (frame_clock_lost || mode_change) flt_q <= FLT_DOWN;
        end
        FLT_DOWN: begin
          if (tgt_a && tgt_b && !frame_clock_lost) begin
            roll_act_q <= ap_ramp_q[RF_ROLLOFF];
            speed_act_q <= speed_eff;
            flt_q <= FLT_UP;
          end
        end
        FLT_UP: begin
          if (frame_clock_lost || mode_change) begin
            flt_q <= FLT_DOWN;
          end else if (tgt_a && tgt_b) begin
            flt_q <= FLT_RUN;
          end
        end
        default: flt_q <= FLT_RUN;
      endcase
    end
  end

  assign sys_mute = (flt_q == FLT_DOWN);
  // Lost frame clock leaves no crossings or ticks, so that mute is instant
  assign sys_instant = (sys_mute && (!ap_ramp_q[RF_RAMP_DN] || frame_clock_lost))
                    || (flt_q == FLT_UP && !ap_ramp_q[RF_RAMP_UP]);

  // Power-down and the ramp on leaving it
  assign power_down_request = ap_misc_q[MISC_PDN];
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pdn_q <= 1'b0;
      pup_q <= 1'b0;
    end else begin
      pdn_q <= power_down_request;
      if (power_down_request || (tgt_a && tgt_b)) begin
        pup_q <= 1'b0;
      end else if (pdn_q) begin
        pup_q <= 1'b1;
      end
    end
  end

  assign instant = sys_instant || power_down_request || (pup_q && !ap_misc_q[MISC_STARTUP]);
  assign mute_a = ap_sil_q[SIL_MUTE_A] || sys_mute || power_down_request;
  assign mute_b = ap_sil_q[SIL_MUTE_B] || sys_mute || power_down_request;

  dlmc_chan #(
    .SILENCE_SAMPLES(SILENCE_SAMPLES),
    .SAMPLE_W(SAMPLE_W)
  ) u_chan_a (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_stb(sample_valid),
    .sample_data(sample_a),
    .frame_tick(frame_tick),
    .attenuation_code(ap_att_a_q),
    .mute_req(mute_a),
    .auto_en(ap_sil_q[SIL_AUTO]),
    .policy(dlmc_policy_e'(ap_ramp_q[RF_POL_LO +: 2])),
    .instant(instant),
    .level_q(lvl_a),
    .auto_muted_q(auto_a),
    .at_target(tgt_a)
  );

  dlmc_chan #(
    .SILENCE_SAMPLES(SILENCE_SAMPLES),
    .SAMPLE_W(SAMPLE_W)
  ) u_chan_b (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_stb(sample_valid),
    .sample_data(sample_b),
    .frame_tick(frame_tick),
    .attenuation_code(ap_att_b_q),
    .mute_req(mute_b),
    .auto_en(ap_sil_q[SIL_AUTO]),
    .policy(dlmc_policy_e'(ap_ramp_q[RF_POL_LO +: 2])),
    .instant(instant),
    .level_q(lvl_b),
    .auto_muted_q(auto_b),
    .at_target(tgt_b)
  );

  // Manual silence shows only once the level has settled at quiescent
  assign cond_a = auto_a || (ap_sil_q[SIL_MUTE_A] && tgt_a);
  assign cond_b = auto_b || (ap_sil_q[SIL_MUTE_B] && tgt_b);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_a_level_q <= '0;
      chan_b_level_q <= '0;
    end else begin
      chan_a_level_q <= auto_a ? LVL_MUTE : lvl_a;
      chan_b_level_q <= auto_b ? LVL_MUTE : lvl_b;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_a_silence_indicator_pin <= 1'b0;
      chan_b_silence_indicator_pin <= 1'b0;
    end else if (ap_sil_q[SIL_COMBINE]) begin
      chan_a_silence_indicator_pin <= cond_a && cond_b;
      chan_b_silence_indicator_pin <= cond_a && cond_b;
    end else begin
      chan_a_silence_indicator_pin <= cond_a;
      chan_b_silence_indicator_pin <= cond_b;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rolloff_select <= 1'b0;
      power_down <= 1'b0;
    end else begin
      rolloff_select <= roll_act_q;
      power_down <= power_down_request;
    end
  end

  // Recovered clock ratio against the frame clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      recovered_clock_ratio_q <= RATIO_256;
      recovered_clock_enable_q <= 1'b1;
    end else begin
      recovered_clock_enable_q <= 1'b1;
      unique case (ap_misc_q[MISC_CLK_LO +: 2])
        CLK_STD: recovered_clock_ratio_q <= (speed_act_q == SPD_QUAD) ? RATIO_128 : RATIO_256;
        CLK_WIDE: begin
          if (speed_act_q == SPD_QUAD) begin
            recovered_clock_ratio_q <= RATIO_128;
          end else if (speed_act_q == SPD_SINGLE) begin
            recovered_clock_ratio_q <= RATIO_512;
          end else begin
            recovered_clock_ratio_q <= RATIO_256;
          end
        end
        CLK_MANUAL: begin
          unique case (ap_misc_q[MISC_RATIO_LO +: 2])
            2'h0: recovered_clock_ratio_q <= RATIO_512;
            2'h1: recovered_clock_ratio_q <= RATIO_256;
            2'h2: recovered_clock_ratio_q <= RATIO_128;
            2'h3: recovered_clock_ratio_q <= RATIO_64;
          endcase
        end
        default: begin
          recovered_clock_ratio_q <= 10'h000;
          recovered_clock_enable_q <= 1'b0;
        end
      endcase
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  pin_combine_a: assert property (
    ap_sil_q[SIL_COMBINE] |=> chan_a_silence_indicator_pin == ($past(cond_a) && $past(cond_b))
                            && chan_b_silence_indicator_pin == chan_a_silence_indicator_pin)
    else $error("combined indicators differ from AND of conditions");
  auto_pin_a: assert property (
    auto_a && !ap_sil_q[SIL_COMBINE] |=> chan_a_silence_indicator_pin
                                        && chan_a_level_q == LVL_MUTE)
    else $error("auto silenced channel not quiescent with indicator");
  manual_pin_a: assert property (
    !auto_a && !ap_sil_q[SIL_COMBINE] && !tgt_a |=> !chan_a_silence_indicator_pin)
    else $error("indicator active before ramp finished");
  freeze_hold_a: assert property (
    misc_q[MISC_FREEZE] |=> $stable(ap_att_a_q) && $stable(ap_sil_q))
    else $error("applied register changed while updates held");
  freeze_apply_a: assert property (
    !misc_q[MISC_FREEZE] |=> ap_att_b_q == $past(att_b_q) && ap_ramp_q == $past(ramp_q))
    else $error("write not applied with updates released");
  pdn_mute_a: assert property (
    power_down_request ##1 power_down_request |=> chan_a_level_q == LVL_MUTE || auto_a)
    else $error("power down did not silence output");
  manual_ratio_a: assert property (
    ap_misc_q[MISC_CLK_LO +: 2] == CLK_MANUAL && ap_misc_q[MISC_RATIO_LO +: 2] == 2'h3
    |=> recovered_clock_ratio_q == RATIO_64)
    else $error("manual ratio 64 not selected");
  lost_mute_a: assert property (
    flt_q == FLT_DOWN && frame_clock_lost |=> lvl_a == LVL_MUTE)
    else $error("lost frame clock did not mute at once");
  fault_unmute_a: assert property (
    flt_q == FLT_UP && !ap_ramp_q[RF_RAMP_UP] && !ap_sil_q[SIL_MUTE_A] && !power_down_request
    |=> lvl_a == {1'b0, $past(ap_att_a_q), 2'b00})
    else $error("unmute after fault not instant with ramp-up clear");
  startup_step_a: assert property (
    pup_q && !ap_misc_q[MISC_STARTUP] && !power_down_request && !ap_sil_q[SIL_MUTE_A] && flt_q == FLT_RUN
    |=> lvl_a == {1'b0, $past(ap_att_a_q), 2'b00})
    else $error("power-up step not direct with startup ramp off");
endmodule

// >>> test/dlmc_src_model.sv
// Purpose: Serial audio source with a frame clock and one sample pair per frame
// Assumes: Frame period of 16 clk cycles; a rising frame edge carries the strobe
// Notes: Data lines move between strobes, so stale data is never mistaken for valid
`timescale 1ns/1ps
module dlmc_src_model #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic [1:0] quiet,
  output logic frame_clock,
  output logic sample_valid,
  output logic [W-1:0] sample_a,
  output logic [W-1:0] sample_b
);
  logic [3:0] cnt_q;
  // Quiet gives zero; otherwise bit 1 clear and bit 0 set, so never zero or all ones
  function automatic logic [W-1:0] pick(input logic q);
    return q ? '0 : ((W'($urandom) & ~W'(2)) | W'(1));
  endfunction
  initial begin
    cnt_q = 4'h0;
    frame_clock = 1'b0;
    sample_valid = 1'b0;
    sample_a = '0;
    sample_b = '0;
  end
  always @(posedge clk) begin
    #1;
    cnt_q = cnt_q + 4'h1;
    frame_clock = cnt_q[3];
    sample_valid = (cnt_q == 4'h8);
    sample_a = sample_valid ? pick(quiet[0]) : ~sample_a;
    sample_b = sample_valid ? pick(quiet[1]) : ~sample_b;
  end
endmodule

// >>> test/testbench.sv
// Purpose: Self-checking bench for the level, mute and control block
// Assumes: Parallel byte port; silence count shortened to 16 samples
// Notes: Reads are checked from a queue by a monitor; other checks are direct
`timescale 1ns/1ps
module testbench;
  import dlmc_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [7:0] reg_rdata_q;
  logic frame_clock, sample_valid;
  logic frame_clock_lost = 1'b0;
  logic [23:0] sample_a, sample_b;
  logic [1:0] detected_speed = 2'h0;
  logic [1:0] speed_range_select = 2'h0;
  logic [1:0] quiet = 2'h0;
  logic [10:0] lvl_a, lvl_b;
  logic pin_a, pin_b, rolloff_select, power_down, clk_en;
  logic [9:0] ratio;
  logic [7:0] exp_q[$];
  logic [7:0] code;
  logic [10:0] cl;
  int fails = 0;
  int n_checks = 0;
  int i;

  dlmc_top #(.SILENCE_SAMPLES(16), .SAMPLE_W(24)) u_dlmc_top (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata_q(reg_rdata_q),
    .frame_clock(frame_clock), .sample_valid(sample_valid), .sample_a(sample_a),
    .sample_b(sample_b), .frame_clock_lost(frame_clock_lost),
    .detected_speed(detected_speed), .speed_range_select(speed_range_select),
    .chan_a_level_q(lvl_a), .chan_b_level_q(lvl_b),
    .chan_a_silence_indicator_pin(pin_a), .chan_b_silence_indicator_pin(pin_b),
    .rolloff_select(rolloff_select), .power_down(power_down),
    .recovered_clock_ratio_q(ratio), .recovered_clock_enable_q(clk_en));

  dlmc_src_model #(.W(24)) u_dlmc_src_model (
    .clk(clk), .quiet(quiet), .frame_clock(frame_clock),
    .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b));

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [10:0] seen, input logic [10:0] expv);
    n_checks++;
    if (seen !== expv) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, expv);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One idle cycle after each access keeps a strobe from being set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    cyc(1);
    reg_we = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] expv);
    exp_q.push_back(expv);
    reg_addr = a;
    reg_re = 1'b1;
    cyc(1);
    reg_re = 1'b0;
    cyc(1);
  endtask

  always @(posedge clk) begin
    if (reg_re === 1'b1 && exp_q.size() > 0) begin
      #2;
      chk(11'(reg_rdata_q), 11'(exp_q.pop_front()));
    end
  end

  // Waits for the first change of a level, then checks where it landed
  task automatic wait_lvl(input int ch, input logic [10:0] expv, input int lim);
    logic [10:0] start;
    int k;
    start = (ch == 0) ? lvl_a : lvl_b;
    k = 0;
    while (((ch == 0) ? lvl_a : lvl_b) === start && k < lim) begin
      cyc(1);
      k++;
    end
    chk((ch == 0) ? lvl_a : lvl_b, expv);
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    end_of_test();
  end

  initial begin
    void'($urandom(34));
    cyc(8);
    sys_rst = 1'b0;
    rd(8'h04, 8'h80);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h07, 8'hb1);
    rd(8'h08, 8'h10);
    rd(8'h09, 8'h00);
    wr(8'h07, 8'h31);
    rd(8'h07, 8'h31);
    code = 8'($urandom_range(255, 1));
    cl = {1'b0, code, 2'b00};
    wr(8'h05, code);
    wait_lvl(0, cl, 20);
    wr(8'h06, 8'hff);
    wait_lvl(1, 11'h3fc, 20);
    wr(8'h04, 8'h90);
    wait_lvl(0, 11'h400, 20);
    cyc(3);
    chk(11'({pin_a, pin_b}), 11'h2);
    wr(8'h04, 8'hb0);
    cyc(4);
    chk(11'({pin_a, pin_b}), 11'h0);
    wr(8'h04, 8'hb8);
    wait_lvl(1, 11'h400, 20);
    cyc(4);
    chk(11'({pin_a, pin_b}), 11'h3);
    wr(8'h04, 8'h80);
    cyc(6);
    chk(lvl_a, cl);
    chk(lvl_b, 11'h3fc);
    // Held writes must not reach the level until the hold is lifted
    wr(8'h08, 8'h30);
    wr(8'h06, 8'h10);
    rd(8'h06, 8'h10);
    cyc(10);
    chk(lvl_b, 11'h3fc);
    wr(8'h08, 8'h10);
    wait_lvl(1, 11'h040, 20);
    wr(8'h07, 8'hb1);
    wr(8'h05, 8'h00);
    wait_lvl(0, cl - 11'h1, 40);
    cyc(28);
    chk(lvl_a, cl - 11'h2);
    wr(8'h07, 8'h31);
    cyc(4);
    chk(lvl_a, 11'h000);
    // Static input never crosses zero, so only the timeout can apply the change
    wr(8'h04, 8'h00);
    quiet = 2'h3;
    // Let a quiet sample land first, so a stale negative sign is no crossing
    cyc(40);
    wr(8'h07, 8'h71);
    wr(8'h05, 8'h02);
    cyc(500 * 16);
    chk(lvl_a, 11'h000);
    wait_lvl(0, 11'h008, 530 * 16);
    wr(8'h07, 8'h31);
    wr(8'h04, 8'h80);
    wait_lvl(0, 11'h400, 20 * 16);
    cyc(3);
    chk(lvl_b, 11'h400);
    chk(11'({pin_a, pin_b}), 11'h3);
    quiet = 2'h2;
    wait_lvl(0, 11'h008, 40);
    cyc(3);
    chk(11'({pin_a, pin_b}), 11'h1);
    wr(8'h07, 8'h35);
    i = 0;
    while (rolloff_select !== 1'b1 && i < 200) begin
      cyc(1);
      i++;
    end
    chk(11'(rolloff_select), 11'h1);
    for (int r = 0; r < 4; r++) begin
      wr(8'h08, 8'h18 | 8'(r));
      cyc(3);
      chk(11'(ratio), 11'(10'h200 >> r));
    end
    wr(8'h08, 8'h1c);
    cyc(3);
    chk(11'(clk_en), 11'h0);
    speed_range_select = SPD_SINGLE;
    wr(8'h08, 8'h14);
    cyc(40);
    chk(11'(ratio), 11'h200);
    speed_range_select = SPD_QUAD;
    wr(8'h08, 8'h10);
    cyc(40);
    chk(11'(ratio), 11'h080);
    wr(8'h07, 8'h94);
    frame_clock_lost = 1'b1;
    cyc(4);
    chk(lvl_a, 11'h400);
    frame_clock_lost = 1'b0;
    cyc(6);
    chk(lvl_a, 11'h008);
    wr(8'h07, 8'h80);
    wait_lvl(0, 11'h400, 20);
    wait_lvl(0, 11'h008, 20);
    wr(8'h08, 8'h90);
    cyc(4);
    chk(11'(power_down), 11'h1);
    chk(lvl_a, 11'h400);
    rd(8'h06, 8'h10);
    wr(8'h08, 8'h00);
    cyc(6);
    chk(11'(power_down), 11'h0);
    chk(lvl_a, 11'h008);
    cyc(4);
    end_of_test();
  end
endmodule
